// *** sprx_top.sv ***
// Serial port: async receiver, sync slave transmitter, AHB-Lite registers.
// Assumes one AHB-Lite master; pins come from outside the clock domain.
`timescale 1ns/10ps
`include "sprx_params.svh"
module sprx_top import sprx_pkg::*; (
	input wire logic clk, // 100 MHz clock
	input wire logic rst_n, // Async reset
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response
	output logic [31:0] hrdata, // AHB read data
	input wire logic dtIn, // Data pin level
	output logic dtOut, // Data pin drive value
	output logic dtOe, // Data pin drive enable
	input wire logic ckIn, // External shift clock
	output logic irq, // Interrupt to CPU
	output logic wake // Wake from sleep
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] dtSync_q;
	logic [2:0] ckSync_q;
	logic dtLvl_q;
	logic ckLvl_q;
	logic ckRise;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dtSync_q <= 3'h7;
			ckSync_q <= 3'h0;
		end else begin
			dtSync_q <= {dtSync_q[1:0], dtIn};
			ckSync_q <= {ckSync_q[1:0], ckIn};
		end
	end

	// A level counts only once the last two stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dtLvl_q <= 1'b1;
			ckLvl_q <= 1'b0;
		end else begin
			if (dtSync_q[1] == dtSync_q[2]) dtLvl_q <= dtSync_q[2];
			if (ckSync_q[1] == ckSync_q[2]) ckLvl_q <= ckSync_q[2];
		end
	end

	assign ckRise = (ckSync_q[1] == ckSync_q[2]) && ckSync_q[2] && !ckLvl_q;

	// ----------------------------------------
	// AHB-Lite slave, zero wait states
	// ----------------------------------------
	logic acc;
	logic [7:0] aIdx;
	logic wr_q;
	logic [7:0] idx_q;
	logic [31:0] hrdata_q;
	logic [7:0] rdMux;
	logic rdRx;

	function automatic logic wrHit(input logic [7:0] idx);
		return wr_q && (idx_q == idx);
	endfunction

	assign acc = hsel && htrans[1] && hready;
	assign aIdx = haddr[9:2];
	assign rdRx = acc && !hwrite && (aIdx == `SPRX_IDX_RXDAT);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			idx_q <= '0;
		end else begin
			wr_q <= acc && hwrite;
			if (acc) idx_q <= aIdx;
		end
	end

	// Read data is caught at the address edge, so data phase has no wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) hrdata_q <= '0;
		else if (acc && !hwrite) hrdata_q <= {24'h000000, rdMux};
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic gie_q, peripheral_interrupt_enable_q, receive_interrupt_enable_q, transmit_interrupt_enable_q;
	logic [7:0] rcsc_q;
	logic [7:0] txsc_q;
	logic [7:0] brg_q;
	logic serial_port_enable, rx9, continuous_receive_enable, clock_source_select, tx9, transmit_enable, sync, high_speed_baud_select;

	assign serial_port_enable = rcsc_q[`SPRX_B_SERIAL_PORT_ENABLE];
	assign rx9 = rcsc_q[`SPRX_B_RX9];
	assign continuous_receive_enable = rcsc_q[`SPRX_B_CONTINUOUS_RECEIVE_ENABLE];
	assign clock_source_select = txsc_q[`SPRX_B_CLOCK_SOURCE_SELECT];
	assign tx9 = txsc_q[`SPRX_B_TX9];
	assign transmit_enable = txsc_q[`SPRX_B_TRANSMIT_ENABLE];
	assign sync = txsc_q[`SPRX_B_SYNC];
	assign high_speed_baud_select = txsc_q[`SPRX_B_HIGH_SPEED_BAUD_SELECT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gie_q <= 1'b0;
			peripheral_interrupt_enable_q <= 1'b0;
		end else if (wrHit(`SPRX_IDX_INTCTL)) begin
			gie_q <= hwdata[`SPRX_B_GIE];
			peripheral_interrupt_enable_q <= hwdata[`SPRX_B_PERIPHERAL_INTERRUPT_ENABLE];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_interrupt_enable_q <= 1'b0;
			transmit_interrupt_enable_q <= 1'b0;
		end else if (wrHit(`SPRX_IDX_PIEN)) begin
			receive_interrupt_enable_q <= hwdata[`SPRX_B_RECEIVE_INTERRUPT_FLAG];
			transmit_interrupt_enable_q <= hwdata[`SPRX_B_TRANSMIT_INTERRUPT_FLAG];
		end
	end

	// Status bits of these two live elsewhere; whole byte stored, status bits masked on read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rcsc_q <= `SPRX_RST_ZERO;
		else if (wrHit(`SPRX_IDX_RCSC)) rcsc_q <= hwdata[7:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) txsc_q <= `SPRX_RST_TXSC;
		else if (wrHit(`SPRX_IDX_TXSC)) txsc_q <= hwdata[7:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) brg_q <= `SPRX_RST_ZERO;
		else if (wrHit(`SPRX_IDX_BRG)) brg_q <= hwdata[7:0];
	end

	// ----------------------------------------
	// Baud rate generator
	// ----------------------------------------
	logic [7:0] brgCnt_q;
	logic [1:0] pre_q;
	logic brgTick;
	logic sTick;

	assign brgTick = (brgCnt_q == 8'h00);
	// Low speed is four times slower: 64 clocks per bit per count
	assign sTick = brgTick && (high_speed_baud_select || pre_q == `SPRX_PRE_LAST);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brgCnt_q <= '0;
			pre_q <= '0;
		end else begin
			brgCnt_q <= brgTick ? brg_q : brgCnt_q - 8'h01;
			if (brgTick) pre_q <= pre_q + 2'h1;
		end
	end

	// ----------------------------------------
	// Receiver and its flags
	// ----------------------------------------
	logic rxEn;
	logic rxDone;
	sprx_char_t rxChar;
	logic receive_interrupt_flag_q, overrun_error_flag_q, framing_error_flag_q, received_ninth_bit_q;
	logic [7:0] rxData_q;
	logic rxTake;

	// Overrun stalls the receiver until continuous receive is cleared
	assign rxEn = serial_port_enable && !sync && continuous_receive_enable && !overrun_error_flag_q;
	// A read in the same cycle frees the holding register
	assign rxTake = rxDone && (!receive_interrupt_flag_q || rdRx);

	sprx_rx u_rx (
		.clk(clk),
		.rst_n(rst_n),
		.en(rxEn),
		.tick(sTick),
		.rxLvl(dtLvl_q),
		.nine(rx9),
		.done(rxDone),
		.rxChar(rxChar)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxData_q <= '0;
			received_ninth_bit_q <= 1'b0;
		end else if (rxTake) begin
			rxData_q <= rxChar.data;
			received_ninth_bit_q <= rxChar.ninth;
		end
	end

	// Set wins over the read that clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) receive_interrupt_flag_q <= 1'b0;
		else if (rxTake) receive_interrupt_flag_q <= 1'b1;
		else if (rdRx) receive_interrupt_flag_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_error_flag_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
		end else if (!continuous_receive_enable) begin
			overrun_error_flag_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
		end else begin
			if (rxDone && !rxTake) overrun_error_flag_q <= 1'b1;
			if (rxTake) framing_error_flag_q <= rxChar.frameErr;
		end
	end

	// ----------------------------------------
	// Synchronous slave transmitter
	// ----------------------------------------
	logic txRun;
	logic bufFull_q;
	logic [8:0] buf_q;
	logic txBusy;
	logic txBit;
	logic txLoad;
	logic transmit_interrupt_flag;

	assign txRun = serial_port_enable && sync && !clock_source_select && transmit_enable;
	assign txLoad = txRun && bufFull_q && !txBusy;
	assign transmit_interrupt_flag = txRun && !bufFull_q;

	// A write over a full buffer replaces the waiting word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bufFull_q <= 1'b0;
			buf_q <= '0;
		end else if (wrHit(`SPRX_IDX_TXDAT)) begin
			bufFull_q <= 1'b1;
			buf_q <= {tx9 & txsc_q[`SPRX_B_TRANSMIT_NINTH_BIT], hwdata[7:0]};
		end else if (txLoad) begin
			bufFull_q <= 1'b0;
		end
	end

	sprx_tx u_tx (
		.clk(clk),
		.rst_n(rst_n),
		.en(txRun),
		.ckRise(ckRise),
		.load(txLoad),
		.word(buf_q),
		.nine(tx9),
		.busy(txBusy),
		.bitOut(txBit)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rdMux = 8'h00;
		case (aIdx)
		`SPRX_IDX_INTCTL: begin
			rdMux[`SPRX_B_GIE] = gie_q;
			rdMux[`SPRX_B_PERIPHERAL_INTERRUPT_ENABLE] = peripheral_interrupt_enable_q;
		end
		`SPRX_IDX_PIFLG: begin
			rdMux[`SPRX_B_RECEIVE_INTERRUPT_FLAG] = receive_interrupt_flag_q;
			rdMux[`SPRX_B_TRANSMIT_INTERRUPT_FLAG] = transmit_interrupt_flag;
		end
		`SPRX_IDX_PIEN: begin
			rdMux[`SPRX_B_RECEIVE_INTERRUPT_FLAG] = receive_interrupt_enable_q;
			rdMux[`SPRX_B_TRANSMIT_INTERRUPT_FLAG] = transmit_interrupt_enable_q;
		end
		`SPRX_IDX_RCSC: begin
			rdMux = rcsc_q & `SPRX_RCSC_MASK;
			rdMux[`SPRX_B_FRAMING_ERROR_FLAG] = framing_error_flag_q;
			rdMux[`SPRX_B_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
			rdMux[`SPRX_B_RECEIVED_NINTH_BIT] = received_ninth_bit_q;
		end
		`SPRX_IDX_RXDAT: rdMux = rxData_q;
		`SPRX_IDX_TXSC: begin
			rdMux = txsc_q & `SPRX_TXSC_MASK;
			rdMux[`SPRX_B_SHIFT_REGISTER_EMPTY] = !txBusy;
		end
		`SPRX_IDX_BRG: rdMux = brg_q;
		default: rdMux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Pin and interrupt outputs
	// ----------------------------------------
	logic dtOut_q, dtOe_q, irq_q, wake_q;
	logic pend;

	assign pend = (receive_interrupt_flag_q && receive_interrupt_enable_q) || (transmit_interrupt_flag && transmit_interrupt_enable_q);
	assign dtOut = dtOut_q;
	assign dtOe = dtOe_q;
	assign irq = irq_q;
	assign wake = wake_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dtOut_q <= 1'b1;
			dtOe_q <= 1'b0;
		end else begin
			dtOut_q <= txBit;
			dtOe_q <= txRun;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q <= pend && gie_q && peripheral_interrupt_enable_q;
			wake_q <= pend;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_freshChar;
		rxDone && !receive_interrupt_flag_q;
	endsequence
	sequence s_flagUp;
		receive_interrupt_flag_q && (rxData_q == $past(rxChar.data));
	endsequence
	sequence s_secondWaits;
		txBusy && bufFull_q;
	endsequence

	property p_rcifSet;
		s_freshChar |=> s_flagUp;
	endproperty
	a_rcifSet: assert property (p_rcifSet) else $error("flag missed");

	property p_ninth;
		s_freshChar ##0 rx9 |=> received_ninth_bit_q == $past(rxChar.ninth);
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit lost");

	property p_overrun;
		rxDone && receive_interrupt_flag_q && !rdRx && continuous_receive_enable |=> overrun_error_flag_q && receive_interrupt_flag_q;
	endproperty
	a_overrun: assert property (p_overrun) else $error("no overrun");

	property p_errClr;
		// Flags drop one edge after the enable bit is seen low
		$fell(continuous_receive_enable) |=> !overrun_error_flag_q && !framing_error_flag_q;
	endproperty
	a_errClr: assert property (p_errClr) else $error("errors kept");

	property p_rxGate;
		!continuous_receive_enable |=> !rxDone;
	endproperty
	a_rxGate: assert property (p_rxGate) else $error("rx while off");

	property p_txifHold;
		s_secondWaits ##0 (acc && !hwrite && aIdx == `SPRX_IDX_PIFLG)
			|=> !hrdata_q[`SPRX_B_TRANSMIT_INTERRUPT_FLAG];
	endproperty
	a_txifHold: assert property (p_txifHold) else $error("transmit_interrupt_flag early");

	property p_loadNow;
		// A write in the load cycle rightly refills the buffer
		txRun && bufFull_q && !txBusy
			&& !(wr_q && idx_q == `SPRX_IDX_TXDAT)
			|=> txBusy ##0 !bufFull_q[*1];
	endproperty
	a_loadNow: assert property (p_loadNow) else $error("no load");

	property p_irqGate;
		!(gie_q && peripheral_interrupt_enable_q) |=> !irq_q;
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("irq ungated");

	property p_wake;
		transmit_interrupt_flag && transmit_interrupt_enable_q |=> wake_q;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_rsvd;
		acc && !hwrite && aIdx == `SPRX_IDX_PIFLG |=> hrdata_q[31:6] == '0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
endmodule

// *** sprx_params.svh ***
// Constants of the serial port: register indexes, bit positions, resets.
// Assumes inclusion by bare name from the package and the modules.
`ifndef SPRX_PARAMS_SVH
`define SPRX_PARAMS_SVH
// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define SPRX_IDX_INTCTL 8'h0B
`define SPRX_IDX_PIFLG 8'h0C
`define SPRX_IDX_RCSC 8'h18
`define SPRX_IDX_TXDAT 8'h19
`define SPRX_IDX_RXDAT 8'h1A
`define SPRX_IDX_PIEN 8'h8C
`define SPRX_IDX_TXSC 8'h98
`define SPRX_IDX_BRG 8'h99
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPRX_RST_ZERO 8'h00
`define SPRX_RST_TXSC 8'h02
// Readable control bits of the two status and control registers
`define SPRX_RCSC_MASK 8'hF0
`define SPRX_TXSC_MASK 8'hF5
// ----------------------------------------
// Bit positions
// ----------------------------------------
`define SPRX_B_GIE 7
`define SPRX_B_PERIPHERAL_INTERRUPT_ENABLE 6
`define SPRX_B_RECEIVE_INTERRUPT_FLAG 5
`define SPRX_B_TRANSMIT_INTERRUPT_FLAG 4
`define SPRX_B_SERIAL_PORT_ENABLE 7
`define SPRX_B_RX9 6
`define SPRX_B_SINGLE_RECEIVE_ENABLE 5
`define SPRX_B_CONTINUOUS_RECEIVE_ENABLE 4
`define SPRX_B_FRAMING_ERROR_FLAG 2
`define SPRX_B_OVERRUN_ERROR_FLAG 1
`define SPRX_B_RECEIVED_NINTH_BIT 0
`define SPRX_B_CLOCK_SOURCE_SELECT 7
`define SPRX_B_TX9 6
`define SPRX_B_TRANSMIT_ENABLE 5
`define SPRX_B_SYNC 4
`define SPRX_B_HIGH_SPEED_BAUD_SELECT 2
`define SPRX_B_SHIFT_REGISTER_EMPTY 1
`define SPRX_B_TRANSMIT_NINTH_BIT 0
// ----------------------------------------
// Bit timing
// ----------------------------------------
`define SPRX_OVS_MID 4'h7
`define SPRX_OVS_LAST 4'hF
`define SPRX_PRE_LAST 2'h3
`define SPRX_LAST8 4'h7
`define SPRX_LAST9 4'h8
`endif

// *** sprx_pkg.sv ***
// Types shared by the serial port modules.
// Assumes sprx_params.svh is on the include path.
package sprx_pkg;
`include "sprx_params.svh"
	typedef struct packed {
		logic frameErr;
		logic ninth;
		logic [7:0] data;
	} sprx_char_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sprx_rxst_t;
	function automatic logic [3:0] sprx_lastBit(input logic nine);
		return nine ? `SPRX_LAST9 : `SPRX_LAST8;
	endfunction
endpackage

// *** sprx_rx.sv ***
// Asynchronous receiver, 16x oversampled, LSB first.
// Assumes a synchronised line level and a one-cycle sample tick.
`timescale 1ns/10ps
`include "sprx_params.svh"
module sprx_rx import sprx_pkg::*; (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset
	input wire logic en, // Receiver enabled
	input wire logic tick, // 16x sample tick
	input wire logic rxLvl, // Filtered line level
	input wire logic nine, // Nine-bit characters
	output logic done, // Character complete pulse
	output sprx_char_t rxChar // Last character
);
	sprx_rxst_t st_q;
	logic [3:0] ovs_q;
	logic [3:0] bit_q;
	logic [8:0] sh_q;
	logic done_q;
	sprx_char_t char_q;

	assign done = done_q;
	assign rxChar = char_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= RX_IDLE;
			ovs_q <= '0;
			bit_q <= '0;
			sh_q <= '0;
			done_q <= 1'b0;
			char_q <= '0;
		end else begin
			done_q <= 1'b0;
			if (!en) begin
				st_q <= RX_IDLE;
			end else begin
				case (st_q)
				RX_IDLE: begin
					ovs_q <= '0;
					if (!rxLvl) st_q <= RX_START;
				end
				RX_START: if (tick) begin
					ovs_q <= ovs_q + 4'h1;
					// Glitch shorter than half a bit is not a start
					if (ovs_q == `SPRX_OVS_MID) begin
						ovs_q <= '0;
						bit_q <= '0;
						st_q <= rxLvl ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: if (tick) begin
					ovs_q <= ovs_q + 4'h1;
					if (ovs_q == `SPRX_OVS_LAST) begin
						sh_q <= {rxLvl, sh_q[8:1]};
						bit_q <= bit_q + 4'h1;
						if (bit_q == sprx_lastBit(nine)) st_q <= RX_STOP;
					end
				end
				RX_STOP: if (tick) begin
					ovs_q <= ovs_q + 4'h1;
					if (ovs_q == `SPRX_OVS_LAST) begin
						done_q <= 1'b1;
						char_q.frameErr <= ~rxLvl;
						char_q.ninth <= nine & sh_q[8];
						char_q.data <= nine ? sh_q[7:0] : sh_q[8:1];
						st_q <= RX_IDLE;
					end
				end
				default: st_q <= RX_IDLE;
				endcase
			end
		end
	end
endmodule

// *** sprx_tx.sv ***
// Synchronous slave transmit shift register, clocked by the master.
// Assumes a one-cycle pulse per rising edge of the external clock.
`timescale 1ns/10ps
`include "sprx_params.svh"
module sprx_tx import sprx_pkg::*; (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset
	input wire logic en, // Slave transmit enabled
	input wire logic ckRise, // External clock rising
	input wire logic load, // Load word, only when idle
	input wire logic [8:0] word, // Word with ninth bit
	input wire logic nine, // Nine-bit characters
	output logic busy, // Shift register holds data
	output logic bitOut // Bit on the data pin
);
	logic [8:0] sh_q;
	logic [3:0] cnt_q;
	logic busy_q;

	assign busy = busy_q;
	assign bitOut = sh_q[0];

	// Bit 0 is on the pin at load; each rising edge moves to the next
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (!en) begin
			busy_q <= 1'b0;
		end else if (load) begin
			sh_q <= word;
			cnt_q <= '0;
			busy_q <= 1'b1;
		end else if (ckRise && busy_q) begin
			sh_q <= {1'b0, sh_q[8:1]};
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == sprx_lastBit(nine)) busy_q <= 1'b0;
		end
	end
endmodule

// *** sprx_link_model.sv ***
// Far side of the serial port: async sender and sync clock master.
// Assumes the bench calls its tasks; times are in ns.
`timescale 1ns/10ps
module sprx_link_model #(
	parameter int BIT_NS = 640, // Async bit time
	parameter int CK_NS = 160 // Link clock period
) (
	output logic dtIn, // Line into the port
	output logic ckIn, // Shift clock into the port
	input logic dtOut, // Port data drive
	input logic dtOe // Port drive enable
);
	// ----------------------------------------
	// Async sender
	// ----------------------------------------
	initial begin
		dtIn = 1'b1;
		ckIn = 1'b0;
	end
	task automatic sendChar(input logic [8:0] d, input int n,
			input logic stopBit);
		// Off the clock edge, so the pin never races the sampler
		#1;
		dtIn = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < n; i++) begin
			dtIn = d[i];
			#(BIT_NS);
		end
		dtIn = stopBit;
		#(BIT_NS);
		// Idle line is high, as a released line would be
		dtIn = 1'b1;
	endtask
	// ----------------------------------------
	// Sync clock master
	// ----------------------------------------
	// Clock stands low outside frames; sampled just before each rise
	task automatic clockWord(input int n, output logic [8:0] got);
		got = 9'h000;
		#1;
		for (int i = 0; i < n; i++) begin
			#(CK_NS / 2);
			got[i] = dtOe ? dtOut : ~dtOut;
			ckIn = 1'b1;
			#(CK_NS / 2);
			ckIn = 1'b0;
		end
	endtask
endmodule

// *** testbench.sv ***
// Self-checking bench of the serial port top over AHB-Lite.
// Assumes sprx_pkg compiled first and the link model beside it.
`timescale 1ns/10ps
module testbench;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, wake;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic dtIn, dtOut, dtOe, ckIn;
	int n_errors = 0;
	int cmp_count = 0;
	sprx_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .dtIn(dtIn), .dtOut(dtOut), .dtOe(dtOe),
		.ckIn(ckIn), .irq(irq), .wake(wake));
	sprx_link_model link_u (.dtIn(dtIn), .ckIn(ckIn), .dtOut(dtOut),
		.dtOe(dtOe));
	// ----------------------------------------
	// Clock, reset, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic conclude();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#600000;
		n_errors++;
		conclude();
	end
	// ----------------------------------------
	// Bus and compare
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Registered outputs are looked at after the edge has settled them
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] idx,
			input logic [7:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h000000, idx, 2'h0};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		bus(1'b1, idx, wd, rd);
	endtask
	task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 8'h00, rd);
		chk(rd, {24'h000000, exp});
	endtask
	task automatic waitRx();
		logic [31:0] rd;
		for (int i = 0; i < 600; i++) begin
			bus(1'b0, 8'h0C, 8'h00, rd);
			if (rd[5] === 1'b1)
				return;
		end
		n_errors++;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdChk(8'h98, 8'h02);
		rdChk(8'h0C, 8'h00);
		rdChk(8'h40, 8'h00);
		wr(8'h0B, 8'hFF);
		rdChk(8'h0B, 8'hC0);
		wr(8'h8C, 8'hFF);
		rdChk(8'h8C, 8'h30);
		wr(8'h19, 8'hFF);
		rdChk(8'h19, 8'h00);
		wr(8'h99, 8'hA7);
		rdChk(8'h99, 8'hA7);
		wr(8'h0B, 8'h00);
		wr(8'h8C, 8'h00);
	endtask
	task automatic t_rx8();
		wr(8'h99, 8'h03);
		wr(8'h98, 8'h04);
		wr(8'h8C, 8'h20);
		wr(8'h18, 8'h90);
		// Divisor counter may still run out an old long count
		waitClk(200);
		link_u.sendChar(9'h0A5, 8, 1'b1);
		waitRx();
		chk({30'h0, wake, irq}, 32'h2);
		wr(8'h0B, 8'hC0);
		waitClk(1);
		chk({30'h0, wake, irq}, 32'h3);
		rdChk(8'h18, 8'h90);
		rdChk(8'h1A, 8'hA5);
		rdChk(8'h0C, 8'h00);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_rx9();
		// Low speed, divisor 0: same bit time through the prescaler
		wr(8'h99, 8'h00);
		wr(8'h98, 8'h00);
		wr(8'h18, 8'hD0);
		link_u.sendChar(9'h13C, 9, 1'b0);
		waitRx();
		rdChk(8'h18, 8'hD5);
		rdChk(8'h1A, 8'h3C);
		wr(8'h18, 8'hC0);
		rdChk(8'h18, 8'hC1);
	endtask
	task automatic t_ovr();
		wr(8'h18, 8'h90);
		link_u.sendChar(9'h011, 8, 1'b1);
		link_u.sendChar(9'h022, 8, 1'b1);
		waitRx();
		rdChk(8'h18, 8'h92);
		rdChk(8'h1A, 8'h11);
		link_u.sendChar(9'h033, 8, 1'b1);
		rdChk(8'h0C, 8'h00);
		wr(8'h18, 8'h80);
		rdChk(8'h18, 8'h80);
	endtask
	task automatic t_tx();
		logic [8:0] got;
		wr(8'h0B, 8'h00);
		wr(8'h8C, 8'h10);
		wr(8'h98, 8'h71);
		waitClk(1);
		chk({31'h0, dtOe}, 32'h1);
		// Word buffered while disabled goes out first
		link_u.clockWord(9, got);
		chk({23'h0, got}, 32'h0FF);
		wr(8'h19, 8'h5A);
		wr(8'h98, 8'h70);
		wr(8'h19, 8'h81);
		rdChk(8'h0C, 8'h00);
		chk({31'h0, wake}, 32'h0);
		link_u.clockWord(9, got);
		chk({23'h0, got}, 32'h15A);
		rdChk(8'h0C, 8'h10);
		chk({31'h0, wake}, 32'h1);
		link_u.clockWord(9, got);
		chk({23'h0, got}, 32'h081);
		wr(8'h0B, 8'hC0);
		waitClk(1);
		chk({31'h0, irq}, 32'h1);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_rx8();
		t_rx9();
		t_ovr();
		t_tx();
		conclude();
	end
endmodule
